// ===== hdl/tbpwm_top.sv
// tbpwm_top: shared period timer plus two 10-bit pwm output channels
// assumes a synchronous register master and a sleep level from the power manager
//
// Operation
// RULE1 - counter clears after limit match; outputs set
// RULE2 - output clears when time base equals duty
// RULE3 - zero duty keeps output inactive whole period
// RULE4 - period match copies duty into compare buffers
// RULE5 - postscaler never affects pwm output
// RULE6 - duty is high byte plus bits 7:6
// RULE7 - duty writes always accepted, no lockout
// RULE8 - time base is counter plus prescaled bits
// RULE9 - pulse equals duty times clock times prescale
// RULE10 - full resolution only at limit 255
// RULE11 - oversized duty leaves pin level unchanged
// RULE12 - sleep freezes counter, state and pin
// RULE13 - output frequency follows system clock
// RULE14 - reset restores registers, pins to input
// RULE15 - control bit 7 enables the module
// RULE16 - control bit 5 reads output level
// RULE17 - control bit 4 inverts the output
// RULE18 - duty keeps contents across ordinary reset
// RULE19 - software sets up pins, control, limit, duty
// RULE20 - software clears flag, configures, starts timer
// RULE21 - software waits match, then enables pin
// RULE22 - first-period wait is optional
// RULE23 - disabled module holds output inactive
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tbpwm_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sleep,
  input  wire logic [11:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic      [1:0]  pwm_wave,
  output logic      [1:0]  pin_o,
  output logic      [1:0]  pin_oe,
  output logic             period_match
);

  tbpwm_pkg::tbpwm_state_type state_r;
  tbpwm_pkg::tbpwm_state_type state_nxt;

  // duty register offset of channel ch
  function automatic logic [11:0] duty_ofs(input int unsigned ch);
    duty_ofs = (ch == 0) ? tbpwm_pkg::OFS_A_DUTY : tbpwm_pkg::OFS_B_DUTY;
  endfunction : duty_ofs

  // control register offset of channel ch
  function automatic logic [11:0] ctl_ofs(input int unsigned ch);
    ctl_ofs = (ch == 0) ? tbpwm_pkg::OFS_A_CONTROL : tbpwm_pkg::OFS_B_CONTROL;
  endfunction : ctl_ofs

  // last value of the prescale counter for a select code
  function automatic logic [5:0] presc_last(input logic [1:0] sel);
    logic [5:0] v;
    v = tbpwm_pkg::PRESC_LAST_1;
    case (sel)
      tbpwm_pkg::PRESC_1:  v = tbpwm_pkg::PRESC_LAST_1;
      tbpwm_pkg::PRESC_4:  v = tbpwm_pkg::PRESC_LAST_4;
      tbpwm_pkg::PRESC_16: v = tbpwm_pkg::PRESC_LAST_16;
      tbpwm_pkg::PRESC_64: v = tbpwm_pkg::PRESC_LAST_64;
      default:             v = tbpwm_pkg::PRESC_LAST_1;
    endcase
    presc_last = v;
  endfunction : presc_last

  // control register image as read by software
  function automatic logic [15:0] ctl_image(
    input logic en,
    input logic lvl,
    input logic inv
  );
    logic [15:0] v;
    v = 16'h0000;
    v[tbpwm_pkg::CTL_EN_BIT]  = en;
    v[tbpwm_pkg::CTL_LVL_BIT] = lvl;
    v[tbpwm_pkg::CTL_INV_BIT] = inv;
    ctl_image = v;
  endfunction : ctl_image

  always_comb
  begin
    logic            tick;
    logic            wrap;
    logic [9:0]      tbase;
    logic [1:0][7:0] keep_hi;
    logic [1:0][1:0] keep_lo;
    tick    = 1'b0;
    wrap    = 1'b0;
    tbase   = 10'h000;
    keep_hi = state_r.duty_hi;
    keep_lo = state_r.duty_lo;
    state_nxt = state_r;
    // read data stands only in the cycle after the read strobe
    state_nxt.rdata = 16'h0000;

    // software writes; duty registers have no lockout in any state
    if (wr)
    begin
      for (int unsigned ch = 0; ch < tbpwm_pkg::NUM_CH; ch++)
      begin
        if (addr == duty_ofs(ch))
        begin
          state_nxt.duty_hi[ch] = wdata[tbpwm_pkg::DUTY_HI_LSB +: 8]; // RULE6 RULE7
          state_nxt.duty_lo[ch] = wdata[tbpwm_pkg::DUTY_LO_LSB +: 2]; // RULE6 RULE7
        end
        else if (addr == ctl_ofs(ch))
        begin
          state_nxt.en[ch]  = wdata[tbpwm_pkg::CTL_EN_BIT]; // RULE15
          state_nxt.inv[ch] = wdata[tbpwm_pkg::CTL_INV_BIT]; // RULE17
        end
      end
      if (addr == tbpwm_pkg::OFS_PERIOD)
      begin
        state_nxt.limit = wdata[7:0];
      end
      else if (addr == tbpwm_pkg::OFS_TIMER_CTL)
      begin
        state_nxt.run    = wdata[tbpwm_pkg::TCTL_RUN_BIT];
        state_nxt.postsc = wdata[tbpwm_pkg::TCTL_POST_LSB +: 4];
        state_nxt.presc  = wdata[tbpwm_pkg::TCTL_PRE_LSB +: 2];
      end
      else if (addr == tbpwm_pkg::OFS_TIMER_STS)
      begin
        // write one to clear; a match in the same cycle wins below
        if (wdata[tbpwm_pkg::TSTS_MATCH_BIT])
        begin
          state_nxt.match_flag = 1'b0;
        end
      end
      else if (addr == tbpwm_pkg::OFS_PIN_DIR)
      begin
        state_nxt.pin_in = wdata[1:0];
      end
    end

    // time base: prescaled low bits under the 8-bit counter, one step per
    // prescaled clock, so everything scales with the system clock
    if (!sleep && state_r.run) // RULE12
    begin
      // a count left above a shorter ratio's end closes the step at once
      if (state_r.pre_cnt >= presc_last(state_r.presc)) // RULE8 RULE13
      begin
        state_nxt.pre_cnt = 6'h00;
        tick = 1'b1;
      end
      else
      begin
        state_nxt.pre_cnt = state_r.pre_cnt + 6'h01;
      end
    end

    if (tick)
    begin
      if (state_r.low == tbpwm_pkg::LOW_LAST) // RULE8
      begin
        state_nxt.low = 2'h0;
        if (state_r.count == state_r.limit) // RULE1
        begin
          state_nxt.count = 8'h00;
          wrap = 1'b1;
        end
        else
        begin
          // counter above a lowered limit just rolls over, no period event
          state_nxt.count = state_r.count + 8'h01;
        end
      end
      else
      begin
        state_nxt.low = state_r.low + 2'h1;
      end
    end
    // compare width is full 10 bits; a short limit simply never reaches
    // the top codes, which is where resolution is lost
    tbase = {state_nxt.count, state_nxt.low}; // RULE8 RULE10

    // the postscaler is stored for software only and feeds nothing
    if (wrap) // RULE5
    begin
      state_nxt.match_flag = 1'b1;
    end

    for (int unsigned ch = 0; ch < tbpwm_pkg::NUM_CH; ch++)
    begin
      if (wrap)
      begin
        // latest written duty, including a write in this very cycle
        state_nxt.dbuf[ch] = {state_nxt.duty_hi[ch], state_nxt.duty_lo[ch]}; // RULE4 RULE6
      end
      if (!state_nxt.en[ch])
      begin
        state_nxt.raw[ch] = 1'b0; // RULE23
      end
      else if (wrap)
      begin
        state_nxt.raw[ch] = (state_nxt.dbuf[ch] != 10'h000); // RULE1 RULE3
      end
      else if (tick && (tbase == state_r.dbuf[ch]))
      begin
        // a duty beyond the period is never met, so the level just holds
        state_nxt.raw[ch] = 1'b0; // RULE2 RULE9 RULE11
      end
      state_nxt.lvl[ch] = state_nxt.raw[ch] ^ state_nxt.inv[ch]; // RULE17
    end

    // register reads
    if (rd)
    begin
      if (addr == tbpwm_pkg::OFS_A_DUTY)
      begin
        state_nxt.rdata = {state_r.duty_hi[0], state_r.duty_lo[0], 6'h00};
      end
      else if (addr == tbpwm_pkg::OFS_A_CONTROL)
      begin
        state_nxt.rdata = ctl_image(state_r.en[0], state_r.lvl[0], state_r.inv[0]); // RULE16
      end
      else if (addr == tbpwm_pkg::OFS_B_DUTY)
      begin
        state_nxt.rdata = {state_r.duty_hi[1], state_r.duty_lo[1], 6'h00};
      end
      else if (addr == tbpwm_pkg::OFS_B_CONTROL)
      begin
        state_nxt.rdata = ctl_image(state_r.en[1], state_r.lvl[1], state_r.inv[1]); // RULE16
      end
      else if (addr == tbpwm_pkg::OFS_PERIOD)
      begin
        state_nxt.rdata = {8'h00, state_r.limit};
      end
      else if (addr == tbpwm_pkg::OFS_TIMER_CTL)
      begin
        state_nxt.rdata = {8'h00, state_r.run, state_r.postsc, 1'b0, state_r.presc};
      end
      else if (addr == tbpwm_pkg::OFS_TIMER_STS)
      begin
        state_nxt.rdata = {15'h0000, state_r.match_flag};
      end
      else if (addr == tbpwm_pkg::OFS_PIN_DIR)
      begin
        state_nxt.rdata = {14'h0000, state_r.pin_in};
      end
      else
      begin
        state_nxt.rdata = 16'h0000;
      end
    end

    // ordinary reset: everything to defaults, pins to input, duty kept
    if (rst)
    begin
      state_nxt         = '0; // RULE14
      state_nxt.limit   = tbpwm_pkg::PERIOD_RST;
      state_nxt.pin_in  = tbpwm_pkg::PIN_DIR_RST; // RULE14
      state_nxt.duty_hi = keep_hi; // RULE18
      state_nxt.duty_lo = keep_lo; // RULE18
    end
  end

  always_ff @(posedge clk)
  begin
    state_r <= state_nxt;
  end

  assign rdata        = state_r.rdata;
  assign pwm_wave     = state_r.lvl;
  assign pin_o        = state_r.lvl;
  assign pin_oe       = ~state_r.pin_in;
  assign period_match = state_r.match_flag;

endmodule : tbpwm_top

`default_nettype wire

// ===== hdl/tbpwm_pkg.sv
// tbpwm_pkg: constants and state type for the two-channel timer-based pwm block
// assumes a 16-bit register port with 12-bit word addresses
package tbpwm_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_CH = 2;

  // register offsets (per-channel pair, then shared timer block)
  localparam logic [11:0] OFS_A_DUTY    = 12'h314;
  localparam logic [11:0] OFS_A_CONTROL = 12'h316;
  localparam logic [11:0] OFS_B_DUTY    = 12'h318;
  localparam logic [11:0] OFS_B_CONTROL = 12'h31A;
  localparam logic [11:0] OFS_PERIOD    = 12'h31C;
  localparam logic [11:0] OFS_TIMER_CTL = 12'h31E;
  localparam logic [11:0] OFS_TIMER_STS = 12'h320;
  localparam logic [11:0] OFS_PIN_DIR   = 12'h322;

  // duty register layout
  localparam int unsigned DUTY_HI_LSB = 8;
  localparam int unsigned DUTY_LO_LSB = 6;

  // control register layout
  localparam int unsigned CTL_EN_BIT  = 7;
  localparam int unsigned CTL_LVL_BIT = 5;
  localparam int unsigned CTL_INV_BIT = 4;

  // timer control layout
  localparam int unsigned TCTL_RUN_BIT  = 7;
  localparam int unsigned TCTL_POST_LSB = 3;
  localparam int unsigned TCTL_PRE_LSB  = 0;

  // timer status layout
  localparam int unsigned TSTS_MATCH_BIT = 0;

  // prescale select codes and their terminal counts (ratio minus one)
  localparam logic [1:0] PRESC_1  = 2'h0;
  localparam logic [1:0] PRESC_4  = 2'h1;
  localparam logic [1:0] PRESC_16 = 2'h2;
  localparam logic [1:0] PRESC_64 = 2'h3;
  localparam logic [5:0] PRESC_LAST_1  = 6'h00;
  localparam logic [5:0] PRESC_LAST_4  = 6'h03;
  localparam logic [5:0] PRESC_LAST_16 = 6'h0F;
  localparam logic [5:0] PRESC_LAST_64 = 6'h3F;
  localparam logic [1:0] LOW_LAST      = 2'h3;

  // reset values
  localparam logic [7:0] PERIOD_RST  = 8'hFF;
  localparam logic [1:0] PIN_DIR_RST = 2'h3;

  typedef struct packed {
    logic [1:0][7:0] duty_hi;
    logic [1:0][1:0] duty_lo;
    logic [1:0]      en;
    logic [1:0]      inv;
    logic [1:0][9:0] dbuf;
    logic [1:0]      raw;
    logic [1:0]      lvl;
    logic [7:0]      limit;
    logic            run;
    logic [1:0]      presc;
    logic [3:0]      postsc;
    logic [5:0]      pre_cnt;
    logic [7:0]      count;
    logic [1:0]      low;
    logic            match_flag;
    logic [1:0]      pin_in;
    logic [15:0]     rdata;
  } tbpwm_state_type;

endpackage : tbpwm_pkg

// ===== verif/tbpwm_properties.sv
// tbpwm_properties: port-level checks on the pwm block, channel a
// assumes bind to tbpwm_top; duty a is written before it is read
`timescale 1ns/1ps
`default_nettype none
module tbpwm_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sleep,
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic [1:0]  pwm_wave,
  input wire logic [1:0]  pin_o,
  input wire logic [1:0]  pin_oe,
  input wire logic        period_match
);
  logic       en_r;
  logic       inv_r;
  logic [9:0] dty_r;
  // shadow of channel a settings, snooped from the register port
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      en_r  <= 1'b0;
      inv_r <= 1'b0;
    end
    else if (wr && addr == 12'h316)
    begin
      en_r  <= wdata[7];
      inv_r <= wdata[4];
    end
    if (wr && addr == 12'h314)
      dty_r <= wdata[15:6];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ctl_rd; rd && addr == 12'h316; endsequence
  sequence s_duty_rd; rd && addr == 12'h314; endsequence
  // three samples off, though the waveform follows the enable in the same cycle
  sequence s_off; !en_r && !$past(en_r) && !$past(en_r, 2) && $stable(inv_r); endsequence
  AST_RESET_OUT:
    assert property ($past(rst) |-> pin_oe == 2'b00 && pwm_wave == 2'b00 && !period_match)
      else $error("outputs not idle after reset");
  AST_RDATA_IDLE:
    assert property (!$past(rd) |-> rdata == 16'h0000) else $error("read data outside slot");
  AST_CTL_READ:
    assert property (s_ctl_rd |=> rdata[15:8] == 8'h00 && rdata[7] == en_r && !rdata[6]
      && rdata[4] == inv_r && rdata[3:0] == 4'h0) else $error("control read wrong");
  AST_DUTY_READ:
    assert property (s_duty_rd |=> rdata == {dty_r, 6'h00}) else $error("duty read wrong");
  AST_PERIOD_SET:
    assert property ($rose(period_match) && en_r && dty_r != 10'h000 |-> pwm_wave[0] != inv_r)
      else $error("output not set at period start");
  AST_DISABLED:
    assert property (s_off |-> pwm_wave[0] == inv_r) else $error("disabled output not idle");
  AST_SLEEP:
    assert property (sleep && $past(sleep) |-> $stable(pwm_wave) && $stable(period_match))
      else $error("state moved in sleep");
  AST_FLAG_HOLD:
    assert property (period_match && !(wr && addr == 12'h320 && wdata[0]) |=> period_match)
      else $error("match flag dropped");
  AST_PIN_WAVE:
    assert property (pin_o == pwm_wave) else $error("pin level differs from waveform");
  AST_LVL_READ:
    assert property (s_ctl_rd |=> rdata[5] == $past(pwm_wave[0]))
      else $error("level readback wrong");
  AST_PIN_DIR:
    assert property (wr && addr == 12'h322 |=> pin_oe == ~$past(wdata[1:0]))
      else $error("pin enable does not follow direction write");
endmodule : tbpwm_properties
bind tbpwm_top tbpwm_properties tbpwm_properties_i (.clk(clk), .rst(rst), .sleep(sleep),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pwm_wave(pwm_wave),
  .pin_o(pin_o), .pin_oe(pin_oe), .period_match(period_match));
`default_nettype wire

// ===== verif/tbpwm_sink.sv
// tbpwm_sink: peripheral-side listener timing the waveform it receives
// assumes the same clock as the pwm block
`timescale 1ns/1ps
`default_nettype none
module tbpwm_sink (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wave,
  output logic      [15:0] hi_n,
  output logic      [15:0] per_n
);
  logic        prev_r;
  logic [15:0] cnt_r;
  logic [15:0] hic_r;
  // rise to rise is one period; the first rise after reset reports the count since reset
  always_ff @(posedge clk)
  begin
    prev_r <= wave;
    if (rst)
    begin
      hi_n  <= 16'h0000;
      per_n <= 16'h0000;
      cnt_r <= 16'h0000;
      hic_r <= 16'h0000;
    end
    else if (wave && !prev_r)
    begin
      per_n <= cnt_r;
      hi_n  <= hic_r;
      cnt_r <= 16'h0001;
      hic_r <= 16'h0001;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      hic_r <= hic_r + 16'(wave);
    end
  end
endmodule : tbpwm_sink
`default_nettype wire

// ===== verif/tbpwm_test.sv
// tbpwm_test: register-driven scenarios for the pwm block
// assumes 5 ns clock; duty values are written before any read
`timescale 1ns/1ps
`default_nettype none
module tbpwm_test;
  logic clk, rst, sleep, wr, rd, period_match, v;
  logic [11:0] addr;
  logic [15:0] wdata, rdata, hi_n, per_n;
  logic [1:0] pwm_wave, pin_o, pin_oe, w;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  tbpwm_top tbpwm_top_i (.clk(clk), .rst(rst), .sleep(sleep), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pwm_wave(pwm_wave), .pin_o(pin_o), .pin_oe(pin_oe),
    .period_match(period_match));
  tbpwm_sink tbpwm_sink_i (.clk(clk), .rst(rst), .wave(pwm_wave[0]), .hi_n(hi_n),
    .per_n(per_n));
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_chk
  task automatic meas(input int n, input logic [15:0] p, input logic [15:0] h);
    tick(n);
    chk(per_n, p);
    chk(hi_n, h);
  endtask : meas
  // waveform bit must keep one level for the whole stretch
  task automatic hold(input int n, input int s, input logic e);
    v = 1'b1;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      v &= (pwm_wave[s] === e);
    end
    chk(16'(v), 16'h0001);
  endtask : hold
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // run is about 3760 cycles; the ceiling leaves wide margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  initial
  begin
    rst = 1'b1; sleep = 1'b0; wr = 1'b0; rd = 1'b0; addr = 12'h000; wdata = 16'h0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(12'h316, 16'h0000);
    rd_chk(12'h31A, 16'h0000);
    rd_chk(12'h324, 16'h0000);
    chk(16'(pin_oe), 16'h0000);
    wr_reg(12'h314, 16'h01BF);
    rd_chk(12'h314, 16'h0180);
    wr_reg(12'h318, 16'h0000);
    wr_reg(12'h31C, 16'h0003);
    wr_reg(12'h316, 16'h0080);
    wr_reg(12'h31A, 16'h0080);
    wr_reg(12'h320, 16'h0001);
    wr_reg(12'h31E, 16'h0080);
    wr_reg(12'h322, 16'h0000);
    meas(40, 16'd16, 16'd6);
    hold(40, 1, 1'b0);
    chk(16'(pin_oe), 16'h0003);
    wr_reg(12'h31E, 16'h00F9);
    meas(200, 16'd64, 16'd24);
    wr_reg(12'h316, 16'h0090);
    meas(200, 16'd64, 16'd40);
    wr_reg(12'h316, 16'h0080);
    wr_reg(12'h314, 16'h0400);
    tick(70);
    hold(140, 0, 1'b1);
    wr_reg(12'h316, 16'h0010);
    tick(2);
    hold(20, 0, 1'b1);
    rd_chk(12'h316, 16'h0030);
    wr_reg(12'h314, 16'h0180);
    wr_reg(12'h316, 16'h0080);
    wr_reg(12'h31E, 16'h0080);
    tick(40);
    @(posedge clk);
    sleep <= 1'b1;
    tick(2);
    w = pwm_wave;
    hold(30, 0, w[0]);
    chk(16'(pwm_wave), 16'(w));
    @(posedge clk);
    sleep <= 1'b0;
    meas(50, 16'd16, 16'd6);
    wr_reg(12'h314, 16'h01C0);
    meas(50, 16'h0010, 16'h0007);
    wr_reg(12'h31E, 16'h0082);
    meas(600, 16'h0100, 16'h0070);
    wr_reg(12'h31E, 16'h0083);
    meas(2200, 16'h0400, 16'h01C0);
    rd_chk(12'h320, 16'h0001);
    wr_reg(12'h31E, 16'h0000);
    wr_reg(12'h320, 16'h0001);
    rd_chk(12'h320, 16'h0000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(12'h314, 16'h01C0);
    rd_chk(12'h316, 16'h0000);
    rd_chk(12'h31C, 16'h00FF);
    chk(16'(pin_oe), 16'h0000);
    end_of_test();
  end
endmodule : tbpwm_test
`default_nettype wire
